/* File: core/pfr_regs.vh */
// command codes, field layouts, reset values and timing for fault limits
`ifndef PFR_REGS_VH
`define PFR_REGS_VH

`define PFR_CMD_CLEAR_FAULTS 8'h03
`define PFR_CMD_UV_ACTION 8'h45
`define PFR_CMD_OC_FAULT_LIMIT 8'h46
`define PFR_CMD_OC_FAULT_ACTION 8'h47
`define PFR_CMD_OC_WARN_LIMIT 8'h4a
`define PFR_CMD_OVERTEMP_FAULT_LIMIT 8'h4f
`define PFR_CMD_OT_FAULT_ACTION 8'h50
`define PFR_CMD_OVERTEMP_WARN_LIMIT 8'h51
`define PFR_CMD_STATUS_BYTE 8'h78
`define PFR_CMD_STATUS_WORD 8'h79
`define PFR_CMD_STATUS_VOUT 8'h7a
`define PFR_CMD_STATUS_IOUT 8'h7b
`define PFR_CMD_STATUS_TEMP 8'h7d

`define PFR_UV_ACTION_VAL 8'hba
`define PFR_OC_ACTION_VAL 8'hfa
`define PFR_OT_ACTION_VAL 8'hf8
`define PFR_OT_FAULT_RST 16'h007d
`define PFR_OT_WARN_RST 16'h005f

// linear word: exponent 15:11, mantissa 10:0
`define PFR_EXP_MSB 15
`define PFR_EXP_LSB 11
`define PFR_MAN_MSB 10
`define PFR_MAN_LSB 0

// sticky flag indices
`define PFR_F_OCF 0
`define PFR_F_OCW 1
`define PFR_F_UVF 2
`define PFR_F_OTF 3
`define PFR_F_OTW 4
`define PFR_F_OTHER 5
`define PFR_NFLAGS 6

// bit positions inside the status bytes
`define PFR_SB_IOUT_OC 4
`define PFR_SB_TEMP 2
`define PFR_SB_OTHER 0
`define PFR_SW_VOUT 15
`define PFR_SW_IOUT 14
`define PFR_SV_UVF 4
`define PFR_SI_OCF 7
`define PFR_SI_OCW 5
`define PFR_ST_OTF 7
`define PFR_ST_OTW 6

// restart timing and hysteresis
`define PFR_CLK_KHZ 100000
`define PFR_RESTART_MS 22
`define PFR_OT_HYST_FIXED 48'h0000_000f_0000

`endif

/* File: core/pfr_lin_dec.v */
// linear-format word to signed fixed point with 16 fraction bits
`default_nettype none
`include "pfr_regs.vh"

module pfr_lin_dec (
	input wire [15:0] word_i,
	output wire signed [47:0] fixed_o
);

	wire signed [47:0] man_x;
	wire [4:0] shamt;

	assign man_x = {{37{word_i[`PFR_MAN_MSB]}},
		word_i[`PFR_MAN_MSB:`PFR_MAN_LSB]};
	// exponent -16..15 biased by 16 is the sign bit flipped
	assign shamt = {~word_i[`PFR_EXP_MSB], word_i[`PFR_EXP_MSB-1:`PFR_EXP_LSB]};
	assign fixed_o = man_x <<< shamt;

endmodule
`default_nettype wire

/* File: core/pfr_dly_timer.v */
// one-shot delay counter with a done pulse
`default_nettype none

module pfr_dly_timer #(
	parameter integer CYCLES = 2200000
) (
	input wire mclk_i,
	input wire srst_i,
	input wire start_i,
	output reg busy_o,
	output reg done_o
);

	reg [31:0] cnt_r;

	always @(posedge mclk_i) begin
		if (srst_i) begin
			cnt_r <= 32'h0000_0000;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				cnt_r <= CYCLES - 1;
				busy_o <= 1'b1;
			end else if (busy_o) begin
				if (cnt_r == 32'h0000_0000) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end else begin
					cnt_r <= cnt_r - 32'h0000_0001;
				end
			end
		end
	end

endmodule
`default_nettype wire

/* File: core/pfr_fault_ctrl.v */
// fault limit command registers, sticky status and shutdown/restart control
//
// Functional notes
// - an undervoltage fault disables the output at once and restarts after 22 ms.
// - each limit word is a 5-bit exponent over an 11-bit mantissa, both signed.
// - an overcurrent fault is flagged when output current reaches its limit.
// - an overcurrent fault sets its status byte, word and iout bits and alerts.
// - an overcurrent fault shuts down at once and restarts after 22 ms.
// - the overcurrent warning sets other, iout bits and alerts, no shutdown.
// - the over-temperature limit resets to 125 and raises alert and fault out.
// - an over-temperature fault shuts down until 15 degrees below the limit.
// - the over-temperature warning resets to 95 and raises only the alert.
// - an undervoltage fault sets other, vout bits and alerts the host.
`default_nettype none
`include "pfr_regs.vh"

module pfr_fault_ctrl #(
	parameter integer RESTART_CYCLES = `PFR_RESTART_MS * `PFR_CLK_KHZ
) (
	input wire mclk_i,
	input wire srst_i,
	input wire [7:0] cmd_code_i,
	input wire cmd_wr_i,
	input wire cmd_rd_i,
	input wire [15:0] cmd_wdata_i,
	output reg [15:0] cmd_rdata_o,
	output reg cmd_rvalid_o,
	output reg cmd_err_o,
	input wire [15:0] iout_meas_i,
	input wire [15:0] temp_meas_i,
	input wire uv_detect_i,
	input wire [15:0] max_current_setting_i,
	output reg conv_enable_o,
	output reg host_alert_out_o,
	output reg regulator_fault_out_o
);

	localparam ST_RUN = 2'd0;
	localparam ST_HICCUP = 2'd1;
	localparam ST_COOL = 2'd2;

	////////////////////////////////////////////////////////////////////////
	// limit registers

	reg [15:0] oc_fault_lim_r;
	reg [15:0] oc_warn_lim_r;
	reg [15:0] ot_fault_lim_r;
	reg [15:0] ot_warn_lim_r;
	reg [`PFR_NFLAGS-1:0] flags_r;
	reg [1:0] state_r;
	reg [1:0] state_nxt;

	// fault limit default is 125% of the max current word
	wire signed [11:0] mcs_man;
	wire signed [11:0] mcs_125;
	wire mcs_ovf;
	wire [15:0] oc_fault_dflt;
	wire [4:0] oc_fault_thresh_exp;
	wire [10:0] oc_fault_thresh_man;
	wire [4:0] oc_warn_thresh_exp;
	wire [10:0] oc_warn_thresh_man;
	wire [4:0] temp_fault_thresh_exp;
	wire [10:0] temp_fault_thresh_man;

	assign mcs_man = {max_current_setting_i[10],
		max_current_setting_i[10:0]};
	assign mcs_125 = mcs_man + (mcs_man >>> 2);
	assign mcs_ovf = mcs_125[11] != mcs_125[10];
	// on mantissa overflow, halve it and bump the exponent; loses one lsb
	assign oc_fault_dflt = mcs_ovf ?
		{max_current_setting_i[15:11] + 5'd1, mcs_125[11:1]} :
		{max_current_setting_i[15:11], mcs_125[10:0]};

	assign oc_fault_thresh_exp = oc_fault_lim_r[`PFR_EXP_MSB:`PFR_EXP_LSB];
	assign oc_fault_thresh_man = oc_fault_lim_r[`PFR_MAN_MSB:`PFR_MAN_LSB];
	assign oc_warn_thresh_exp = oc_warn_lim_r[`PFR_EXP_MSB:`PFR_EXP_LSB];
	assign oc_warn_thresh_man = oc_warn_lim_r[`PFR_MAN_MSB:`PFR_MAN_LSB];
	assign temp_fault_thresh_exp = ot_fault_lim_r[`PFR_EXP_MSB:`PFR_EXP_LSB];
	assign temp_fault_thresh_man = ot_fault_lim_r[`PFR_MAN_MSB:`PFR_MAN_LSB];

	always @(posedge mclk_i) begin
		if (srst_i) begin
			oc_fault_lim_r <= oc_fault_dflt;
			oc_warn_lim_r <= max_current_setting_i;
			ot_fault_lim_r <= `PFR_OT_FAULT_RST;
			ot_warn_lim_r <= `PFR_OT_WARN_RST;
		end else if (cmd_wr_i) begin
			if (cmd_code_i == `PFR_CMD_OC_FAULT_LIMIT) begin
				oc_fault_lim_r <= cmd_wdata_i;
			end else if (cmd_code_i == `PFR_CMD_OC_WARN_LIMIT) begin
				oc_warn_lim_r <= cmd_wdata_i;
			end else if (cmd_code_i == `PFR_CMD_OVERTEMP_FAULT_LIMIT) begin
				ot_fault_lim_r <= cmd_wdata_i;
			end else if (cmd_code_i == `PFR_CMD_OVERTEMP_WARN_LIMIT) begin
				ot_warn_lim_r <= cmd_wdata_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// threshold comparison in fixed point

	wire signed [47:0] iout_fx;
	wire signed [47:0] temp_fx;
	wire signed [47:0] ocf_fx;
	wire signed [47:0] ocw_fx;
	wire signed [47:0] otf_fx;
	wire signed [47:0] otw_fx;
	wire signed [47:0] ot_cool_fx;

	pfr_lin_dec u_dec_iout (
		.word_i(iout_meas_i),
		.fixed_o(iout_fx)
	);
	pfr_lin_dec u_dec_temp (
		.word_i(temp_meas_i),
		.fixed_o(temp_fx)
	);
	pfr_lin_dec u_dec_ocf (
		.word_i({oc_fault_thresh_exp, oc_fault_thresh_man}),
		.fixed_o(ocf_fx)
	);
	pfr_lin_dec u_dec_ocw (
		.word_i({oc_warn_thresh_exp, oc_warn_thresh_man}),
		.fixed_o(ocw_fx)
	);
	pfr_lin_dec u_dec_otf (
		.word_i({temp_fault_thresh_exp, temp_fault_thresh_man}),
		.fixed_o(otf_fx)
	);
	pfr_lin_dec u_dec_otw (
		.word_i(ot_warn_lim_r),
		.fixed_o(otw_fx)
	);

	wire ocf_hit;
	wire ocw_hit;
	wire otf_hit;
	wire otw_hit;
	wire ot_cooled;

	assign ocf_hit = iout_fx >= ocf_fx;
	assign ocw_hit = iout_fx >= ocw_fx;
	assign otf_hit = temp_fx >= otf_fx;
	assign otw_hit = temp_fx >= otw_fx;
	assign ot_cool_fx = otf_fx - `PFR_OT_HYST_FIXED;
	assign ot_cooled = temp_fx <= ot_cool_fx;

	////////////////////////////////////////////////////////////////////////
	// sticky status flags

	reg [`PFR_NFLAGS-1:0] set_vec;
	reg [`PFR_NFLAGS-1:0] clr_vec;

	always @* begin
		set_vec = {`PFR_NFLAGS{1'b0}};
		set_vec[`PFR_F_OCF] = ocf_hit;
		set_vec[`PFR_F_OCW] = ocw_hit;
		set_vec[`PFR_F_UVF] = uv_detect_i;
		set_vec[`PFR_F_OTF] = otf_hit;
		set_vec[`PFR_F_OTW] = otw_hit;
		set_vec[`PFR_F_OTHER] = ocw_hit | uv_detect_i;
	end

	// clear all, or write one to clear inside a status command
	always @* begin
		clr_vec = {`PFR_NFLAGS{1'b0}};
		if (cmd_wr_i) begin
			if (cmd_code_i == `PFR_CMD_CLEAR_FAULTS) begin
				clr_vec = {`PFR_NFLAGS{1'b1}};
			end else if (cmd_code_i == `PFR_CMD_STATUS_BYTE) begin
				clr_vec[`PFR_F_OCF] = cmd_wdata_i[`PFR_SB_IOUT_OC];
				clr_vec[`PFR_F_OTHER] = cmd_wdata_i[`PFR_SB_OTHER];
			end else if (cmd_code_i == `PFR_CMD_STATUS_VOUT) begin
				clr_vec[`PFR_F_UVF] = cmd_wdata_i[`PFR_SV_UVF];
			end else if (cmd_code_i == `PFR_CMD_STATUS_IOUT) begin
				clr_vec[`PFR_F_OCF] = cmd_wdata_i[`PFR_SI_OCF];
				clr_vec[`PFR_F_OCW] = cmd_wdata_i[`PFR_SI_OCW];
			end else if (cmd_code_i == `PFR_CMD_STATUS_TEMP) begin
				clr_vec[`PFR_F_OTF] = cmd_wdata_i[`PFR_ST_OTF];
				clr_vec[`PFR_F_OTW] = cmd_wdata_i[`PFR_ST_OTW];
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `PFR_NFLAGS; gi = gi + 1) begin : g_flag
			always @(posedge mclk_i) begin
				if (srst_i) begin
					flags_r[gi] <= 1'b0;
				end else if (set_vec[gi]) begin
					flags_r[gi] <= 1'b1;
				end else if (clr_vec[gi]) begin
					flags_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	wire temp_any;
	wire [7:0] stat_byte;
	wire [15:0] stat_word;
	wire [7:0] stat_vout;
	wire [7:0] stat_iout;
	wire [7:0] stat_temp;

	assign temp_any = flags_r[`PFR_F_OTF] | flags_r[`PFR_F_OTW];
	assign stat_byte = {3'b000, flags_r[`PFR_F_OCF], 1'b0, temp_any, 1'b0,
		flags_r[`PFR_F_OTHER]};
	assign stat_word = {flags_r[`PFR_F_UVF],
		flags_r[`PFR_F_OCF] | flags_r[`PFR_F_OCW], 6'b00_0000, stat_byte};
	assign stat_vout = {3'b000, flags_r[`PFR_F_UVF], 4'h0};
	assign stat_iout = {flags_r[`PFR_F_OCF], 1'b0, flags_r[`PFR_F_OCW],
		5'b0_0000};
	assign stat_temp = {flags_r[`PFR_F_OTF], flags_r[`PFR_F_OTW], 6'b00_0000};

	always @(posedge mclk_i) begin
		if (srst_i) begin
			host_alert_out_o <= 1'b0;
			regulator_fault_out_o <= 1'b0;
		end else begin
			host_alert_out_o <= |(set_vec | (flags_r & ~clr_vec));
			regulator_fault_out_o <= set_vec[`PFR_F_OTF] |
				(flags_r[`PFR_F_OTF] & ~clr_vec[`PFR_F_OTF]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shutdown and restart

	wire tmr_start;
	wire tmr_done;

	assign tmr_start = (state_r != ST_HICCUP) && (state_nxt == ST_HICCUP);

	pfr_dly_timer #(
		.CYCLES(RESTART_CYCLES)
	) u_restart (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.start_i(tmr_start),
		.busy_o(),
		.done_o(tmr_done)
	);

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (otf_hit) begin
					state_nxt = ST_COOL;
				end else if (ocf_hit | uv_detect_i) begin
					state_nxt = ST_HICCUP;
				end
			end
			ST_HICCUP: begin
				if (otf_hit) begin
					state_nxt = ST_COOL;
				end else if (tmr_done) begin
					state_nxt = ST_RUN;
				end
			end
			ST_COOL: begin
				if (ot_cooled) begin
					state_nxt = ST_RUN;
				end
			end
			default: begin
				state_nxt = ST_RUN;
			end
		endcase
	end

	always @(posedge mclk_i) begin
		if (srst_i) begin
			state_r <= ST_RUN;
			conv_enable_o <= 1'b1;
		end else begin
			state_r <= state_nxt;
			// output off on the next edge
			conv_enable_o <= state_nxt == ST_RUN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command reads

	reg [15:0] rd_mux;
	reg rd_hit;
	reg wr_hit;

	always @* begin
		rd_hit = 1'b1;
		rd_mux = 16'h0000;
		if (cmd_code_i == `PFR_CMD_OC_FAULT_LIMIT) begin
			rd_mux = oc_fault_lim_r;
		end else if (cmd_code_i == `PFR_CMD_OC_FAULT_ACTION) begin
			rd_mux = {8'h00, `PFR_OC_ACTION_VAL};
		end else if (cmd_code_i == `PFR_CMD_OC_WARN_LIMIT) begin
			rd_mux = oc_warn_lim_r;
		end else if (cmd_code_i == `PFR_CMD_OVERTEMP_FAULT_LIMIT) begin
			rd_mux = ot_fault_lim_r;
		end else if (cmd_code_i == `PFR_CMD_OT_FAULT_ACTION) begin
			rd_mux = {8'h00, `PFR_OT_ACTION_VAL};
		end else if (cmd_code_i == `PFR_CMD_OVERTEMP_WARN_LIMIT) begin
			rd_mux = ot_warn_lim_r;
		end else if (cmd_code_i == `PFR_CMD_UV_ACTION) begin
			rd_mux = {8'h00, `PFR_UV_ACTION_VAL};
		end else if (cmd_code_i == `PFR_CMD_STATUS_BYTE) begin
			rd_mux = {8'h00, stat_byte};
		end else if (cmd_code_i == `PFR_CMD_STATUS_WORD) begin
			rd_mux = stat_word;
		end else if (cmd_code_i == `PFR_CMD_STATUS_VOUT) begin
			rd_mux = {8'h00, stat_vout};
		end else if (cmd_code_i == `PFR_CMD_STATUS_IOUT) begin
			rd_mux = {8'h00, stat_iout};
		end else if (cmd_code_i == `PFR_CMD_STATUS_TEMP) begin
			rd_mux = {8'h00, stat_temp};
		end else begin
			rd_hit = 1'b0;
		end
	end

	// action codes are fixed; writing them is refused
	always @* begin
		wr_hit = (cmd_code_i == `PFR_CMD_CLEAR_FAULTS) ||
			(cmd_code_i == `PFR_CMD_OC_FAULT_LIMIT) ||
			(cmd_code_i == `PFR_CMD_OC_WARN_LIMIT) ||
			(cmd_code_i == `PFR_CMD_OVERTEMP_FAULT_LIMIT) ||
			(cmd_code_i == `PFR_CMD_OVERTEMP_WARN_LIMIT) ||
			(cmd_code_i == `PFR_CMD_STATUS_BYTE) ||
			(cmd_code_i == `PFR_CMD_STATUS_VOUT) ||
			(cmd_code_i == `PFR_CMD_STATUS_IOUT) ||
			(cmd_code_i == `PFR_CMD_STATUS_TEMP);
	end

	always @(posedge mclk_i) begin
		if (srst_i) begin
			cmd_rdata_o <= 16'h0000;
			cmd_rvalid_o <= 1'b0;
			cmd_err_o <= 1'b0;
		end else begin
			cmd_rvalid_o <= cmd_rd_i & rd_hit;
			cmd_err_o <= (cmd_rd_i & ~rd_hit) | (cmd_wr_i & ~wr_hit);
			if (cmd_rd_i) begin
				cmd_rdata_o <= rd_mux;
			end
		end
	end

endmodule
`default_nettype wire

/* File: testbench/pfr_fault_checker.sv */
// concurrent checks on the ports of the fault limit block
`default_nettype none
`include "pfr_regs.vh"
module pfr_fault_checker #(
	parameter integer RESTART_CYCLES = 2200000
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic cmd_wr_i,
	input wire logic cmd_rd_i,
	input wire logic [15:0] cmd_wdata_i,
	input wire logic [15:0] cmd_rdata_o,
	input wire logic cmd_rvalid_o,
	input wire logic cmd_err_o,
	input wire logic [15:0] iout_meas_i,
	input wire logic [15:0] temp_meas_i,
	input wire logic uv_detect_i,
	input wire logic [15:0] max_current_setting_i,
	input wire logic conv_enable_o,
	input wire logic host_alert_out_o,
	input wire logic regulator_fault_out_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] off_cnt_r;
	// counts the cycles the converter stays off
	always @(posedge mclk_i) begin
		if (srst_i || conv_enable_o)
			off_cnt_r <= 32'h0000_0000;
		else
			off_cnt_r <= off_cnt_r + 32'h0000_0001;
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	sequence s_shut;
		!conv_enable_o && host_alert_out_o;
	endsequence
	sequence s_ro_write;
		cmd_wr_i && (cmd_code_i == `PFR_CMD_OC_FAULT_ACTION ||
			cmd_code_i == `PFR_CMD_OT_FAULT_ACTION ||
			cmd_code_i == `PFR_CMD_UV_ACTION);
	endsequence
	property p_rd_ans;
		cmd_rd_i |=> cmd_rvalid_o || cmd_err_o;
	endproperty
	property p_rv_cause;
		cmd_rvalid_o |-> $past(cmd_rd_i);
	endproperty
	property p_ro_ref;
		s_ro_write |=> cmd_err_o;
	endproperty
	property p_uv_shut;
		$rose(uv_detect_i) |=> s_shut;
	endproperty
	property p_hold;
		host_alert_out_o && !cmd_wr_i && !$past(cmd_wr_i) |=> host_alert_out_o;
	endproperty
	property p_vrf;
		regulator_fault_out_o |-> host_alert_out_o;
	endproperty
	property p_ot_off;
		$rose(regulator_fault_out_o) |-> !conv_enable_o;
	endproperty
	property p_restart;
		$rose(conv_enable_o) && !regulator_fault_out_o && !$past(srst_i) |->
			off_cnt_r >= RESTART_CYCLES + 1 && off_cnt_r <= RESTART_CYCLES + 2;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	a_rv_cause: assert property (p_rv_cause) else $error("stray read valid");
	a_ro_ref: assert property (p_ro_ref) else $error("read-only write taken");
	a_uv_shut: assert property (p_uv_shut) else $error("no uv shutdown");
	a_hold: assert property (p_hold) else $error("alert dropped");
	a_vrf: assert property (p_vrf) else $error("fault out without alert");
	a_ot_off: assert property (p_ot_off) else $error("no thermal shutdown");
	a_restart: assert property (p_restart) else $error("restart delay off");
endmodule
bind pfr_fault_ctrl pfr_fault_checker #(.RESTART_CYCLES(RESTART_CYCLES)) chk_u (
	.mclk_i(mclk_i), .srst_i(srst_i), .cmd_code_i(cmd_code_i),
	.cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i), .cmd_wdata_i(cmd_wdata_i),
	.cmd_rdata_o(cmd_rdata_o), .cmd_rvalid_o(cmd_rvalid_o),
	.cmd_err_o(cmd_err_o), .iout_meas_i(iout_meas_i),
	.temp_meas_i(temp_meas_i), .uv_detect_i(uv_detect_i),
	.max_current_setting_i(max_current_setting_i),
	.conv_enable_o(conv_enable_o), .host_alert_out_o(host_alert_out_o),
	.regulator_fault_out_o(regulator_fault_out_o)
);
`default_nettype wire

/* File: testbench/pfr_host_model.sv */
// host model that issues command reads and writes
`default_nettype none
module pfr_host_model (
	input wire logic mclk_i,
	output logic [7:0] cmd_code_o,
	output logic cmd_wr_o,
	output logic cmd_rd_o,
	output logic [15:0] cmd_wdata_o,
	input wire logic [15:0] cmd_rdata_i,
	input wire logic cmd_rvalid_i,
	input wire logic cmd_err_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_code_o = 8'h00;
		cmd_wr_o = 1'b0;
		cmd_rd_o = 1'b0;
		cmd_wdata_o = 16'h0000;
	end
	task wr(input logic [7:0] c, input logic [15:0] w, output logic e);
		@(posedge mclk_i);
		cmd_code_o <= c;
		cmd_wdata_o <= w;
		cmd_wr_o <= 1'b1;
		@(posedge mclk_i);
		cmd_wr_o <= 1'b0;
		// data released: stale value must not be relied on
		cmd_wdata_o <= ~w;
		#1 e = cmd_err_i;
	endtask
	// a missing answer comes back as unknown data
	task rd(input logic [7:0] c, output logic [16:0] r);
		@(posedge mclk_i);
		cmd_code_o <= c;
		cmd_rd_o <= 1'b1;
		@(posedge mclk_i);
		cmd_rd_o <= 1'b0;
		#1 r = cmd_rvalid_i ? {1'b0, cmd_rdata_i} : {cmd_err_i, 16'hxxxx};
	endtask
endmodule
`default_nettype wire

/* File: testbench/test_pfr_fault_ctrl.sv */
// testbench for the fault limit and response block
`default_nettype none
`include "pfr_regs.vh"
module test_pfr_fault_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	localparam integer RST = 20;
	logic mclk_i;
	logic srst_i = 1'b1;
	logic uv_detect_i = 1'b0;
	logic [15:0] iout_meas_i = 16'h0000;
	logic [15:0] temp_meas_i = 16'h0019;
	logic [15:0] max_cur = 16'h0064;
	logic [7:0] cmd_code_i;
	logic cmd_wr_i, cmd_rd_i, cmd_rvalid_o, cmd_err_o;
	logic [15:0] cmd_wdata_i, cmd_rdata_o;
	logic conv_enable_o, host_alert_out_o, regulator_fault_out_o;
	int err_count = 0;
	int n_tests = 0;
	int n;
	logic [16:0] r;
	logic e;
	logic [7:0] rcode [7] = '{8'h4f, 8'h51, 8'h4a, 8'h46, 8'h47, 8'h50, 8'h45};
	logic [15:0] rval [7] = '{16'h007d, 16'h005f, 16'h0064, 16'h007d,
		16'h00fa, 16'h00f8, 16'h00ba};
	logic [7:0] rocode [4] = '{8'h45, 8'h47, 8'h50, 8'h79};
	pfr_fault_ctrl #(.RESTART_CYCLES(RST)) dut_u (
		.mclk_i(mclk_i), .srst_i(srst_i), .cmd_code_i(cmd_code_i),
		.cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i), .cmd_wdata_i(cmd_wdata_i),
		.cmd_rdata_o(cmd_rdata_o), .cmd_rvalid_o(cmd_rvalid_o),
		.cmd_err_o(cmd_err_o), .iout_meas_i(iout_meas_i),
		.temp_meas_i(temp_meas_i), .uv_detect_i(uv_detect_i),
		.max_current_setting_i(max_cur), .conv_enable_o(conv_enable_o),
		.host_alert_out_o(host_alert_out_o),
		.regulator_fault_out_o(regulator_fault_out_o)
	);
	pfr_host_model host_u (
		.mclk_i(mclk_i), .cmd_code_o(cmd_code_i), .cmd_wr_o(cmd_wr_i),
		.cmd_rd_o(cmd_rd_i), .cmd_wdata_o(cmd_wdata_i),
		.cmd_rdata_i(cmd_rdata_o), .cmd_rvalid_i(cmd_rvalid_o),
		.cmd_err_i(cmd_err_o)
	);
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	task close_out;
		if (err_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [16:0] g, input logic [16:0] x);
		n_tests++;
		if (g !== x) begin
			$display("BAD %0t got %h exp %h", $time, g, x);
			err_count++;
		end
	endtask
	task rc(input logic [7:0] c, input logic [15:0] x);
		host_u.rd(c, r);
		chk(r, {1'b0, x});
	endtask
	task wc(input logic [7:0] c, input logic [15:0] w, input logic x);
		host_u.wr(c, w, e);
		chk(e, x);
	endtask
	task cyc(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask
	// bounded wait for the converter to come back on
	task wait_on;
		n = 0;
		while (conv_enable_o !== 1'b1 && n < 4 * RST) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
	endtask
	initial begin
		#100us;
		err_count++;
		close_out;
	end
	initial begin
		repeat (20) @(posedge mclk_i);
		srst_i <= 1'b0;
		for (int i = 0; i < 7; i++) rc(rcode[i], rval[i]);
		host_u.rd(8'h99, r);
		chk(r[16], 1'b1);
		for (int i = 0; i < 4; i++) wc(rocode[i], 16'h0000, 1'b1);
		rc(`PFR_CMD_OC_FAULT_ACTION, 16'h00fa);
		wc(`PFR_CMD_OC_WARN_LIMIT, 16'h0050, 1'b0);
		wc(`PFR_CMD_OC_FAULT_LIMIT, 16'h0070, 1'b0);
		rc(`PFR_CMD_OC_WARN_LIMIT, 16'h0050);
		// 80.5 A written with exponent -1 crosses only the warning
		@(posedge mclk_i) iout_meas_i <= 16'hf8a1;
		cyc(3);
		chk(host_alert_out_o, 1'b1);
		chk(conv_enable_o, 1'b1);
		@(posedge mclk_i) iout_meas_i <= 16'h0000;
		rc(`PFR_CMD_STATUS_IOUT, 16'h0020);
		rc(`PFR_CMD_STATUS_WORD, 16'h4001);
		wc(`PFR_CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
		cyc(2);
		chk(host_alert_out_o, 1'b0);
		rc(`PFR_CMD_STATUS_WORD, 16'h0000);
		@(posedge mclk_i) iout_meas_i <= 16'h006f;
		cyc(3);
		chk(conv_enable_o, 1'b1);
		@(posedge mclk_i) iout_meas_i <= 16'h0070;
		@(posedge mclk_i) iout_meas_i <= 16'h0000;
		#1 chk(conv_enable_o, 1'b0);
		wait_on;
		chk(n >= RST + 1 && n <= RST + 3, 1'b1);
		chk(host_alert_out_o, 1'b1);
		rc(`PFR_CMD_STATUS_BYTE, 16'h0011);
		rc(`PFR_CMD_STATUS_IOUT, 16'h00a0);
		rc(`PFR_CMD_STATUS_WORD, 16'h4011);
		wc(`PFR_CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
		@(posedge mclk_i) uv_detect_i <= 1'b1;
		@(posedge mclk_i) uv_detect_i <= 1'b0;
		#1 chk(conv_enable_o, 1'b0);
		wait_on;
		chk(n >= RST + 1 && n <= RST + 3, 1'b1);
		chk(host_alert_out_o, 1'b1);
		rc(`PFR_CMD_STATUS_VOUT, 16'h0010);
		rc(`PFR_CMD_STATUS_WORD, 16'h8001);
		wc(`PFR_CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
		@(posedge mclk_i) temp_meas_i <= 16'h005f;
		cyc(3);
		chk({regulator_fault_out_o, host_alert_out_o}, 2'b01);
		chk(conv_enable_o, 1'b1);
		rc(`PFR_CMD_STATUS_TEMP, 16'h0040);
		rc(`PFR_CMD_STATUS_BYTE, 16'h0004);
		@(posedge mclk_i) temp_meas_i <= 16'h007d;
		cyc(3);
		chk({regulator_fault_out_o, conv_enable_o}, 2'b10);
		rc(`PFR_CMD_STATUS_TEMP, 16'h00c0);
		// one degree short of the hysteresis must keep it off past the timer
		@(posedge mclk_i) temp_meas_i <= 16'h006f;
		cyc(RST + 10);
		chk(conv_enable_o, 1'b0);
		@(posedge mclk_i) temp_meas_i <= 16'h006e;
		cyc(3);
		chk(conv_enable_o, 1'b1);
		// warning still present: its clear loses, the fault clear lands
		wc(`PFR_CMD_STATUS_TEMP, 16'h00c0, 1'b0);
		rc(`PFR_CMD_STATUS_TEMP, 16'h0040);
		chk(regulator_fault_out_o, 1'b0);
		// second reset with a larger max current: fault default renormalises
		@(posedge mclk_i) begin
			srst_i <= 1'b1;
			temp_meas_i <= 16'h0019;
			max_cur <= 16'h03e8;
		end
		repeat (2) @(posedge mclk_i);
		srst_i <= 1'b0;
		cyc(2);
		chk({conv_enable_o, host_alert_out_o}, 2'b10);
		rc(`PFR_CMD_OC_FAULT_LIMIT, 16'h0a71);
		rc(`PFR_CMD_OC_WARN_LIMIT, 16'h03e8);
		rc(`PFR_CMD_OVERTEMP_FAULT_LIMIT, 16'h007d);
		rc(`PFR_CMD_STATUS_WORD, 16'h0000);
		close_out;
	end
endmodule
`default_nettype wire
